/* File: shared/ssm_pkg.sv */
// shared constants for the serial switch monitor
package ssm_pkg;
    localparam int NUM_INPUTS = 16;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [15:0] SW_RESET_MASK = 16'h0000;
    localparam int SYNC_STAGES = 2;
    localparam int CLK_SYS_PERIOD_NS = 25;
    localparam int MIN_LINK_HALF_NS = 100;
    localparam int MIN_LINK_HALF_CYCLES = (MIN_LINK_HALF_NS + CLK_SYS_PERIOD_NS - 1) / CLK_SYS_PERIOD_NS;
    typedef enum logic [1:0] {
        SSM_IDLE = 2'b00,
        SSM_SEL_WAIT = 2'b01,
        SSM_SHIFTING = 2'b11
    } ssm_state_type;
endpackage

/* File: rtl/ssm_sync.sv */
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module ssm_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            meta_q <= INIT;
            sync_out <= INIT;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

/* File: rtl/ssm_top.sv */
// serial switch input monitor with maskable change interrupt
`timescale 1ns/1ps
module ssm_top #(
    parameter int WIDTH = ssm_pkg::NUM_INPUTS
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] switch_input_pins,
    input wire logic input_enable,
    input wire logic chip_select_n,
    input wire logic serial_clk,
    input wire logic shift_data_in,
    output logic shift_data_out,
    output logic shift_data_out_oe,
    output logic irq_n_out,
    output logic irq_n_oe,
    output logic [WIDTH-1:0] status_out,
    output logic [WIDTH-1:0] mask_out
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [WIDTH-1:0] pins_s;
    logic en_s;
    logic cs_n_s;
    logic sclk_s;
    logic sdi_s;

    ssm_sync #(.WIDTH(WIDTH), .INIT('0)) u_sync_pins (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .async_in(switch_input_pins),
        .sync_out(pins_s)
    );

    ssm_sync #(.WIDTH(4), .INIT(4'b0100)) u_sync_ctl (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .async_in({input_enable, chip_select_n, serial_clk, shift_data_in}),
        .sync_out({en_s, cs_n_s, sclk_s, sdi_s})
    );

    // ****************************************
    // edge detection
    // ****************************************
    logic cs_n_q;
    logic sclk_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cs_n_q <= 1'b1;
            sclk_q <= 1'b0;
        end else begin
            cs_n_q <= cs_n_s;
            sclk_q <= sclk_s;
        end
    end

    wire cs_fall = cs_n_q & ~cs_n_s;
    wire cs_rise = ~cs_n_q & cs_n_s;
    wire selected = ~cs_n_s & ~cs_n_q;
    // clock edges count only while selected
    wire sclk_rise = selected & ~sclk_q & sclk_s;
    wire sclk_fall = selected & sclk_q & ~sclk_s;

    // ****************************************
    // held inputs
    // ****************************************
    logic [WIDTH-1:0] held_q;
    logic [WIDTH-1:0] held_d;

    // freeze on enable low
    assign held_d = en_s ? pins_s : held_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            held_q <= '0;
        end else begin
            held_q <= held_d;
        end
    end

    // ****************************************
    // serial state machine
    // ****************************************
    ssm_pkg::ssm_state_type state_q;
    ssm_pkg::ssm_state_type state_d;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ssm_pkg::SSM_IDLE: begin
                if (cs_fall) begin
                    state_d = ssm_pkg::SSM_SEL_WAIT;
                end
            end
            ssm_pkg::SSM_SEL_WAIT: begin
                if (cs_rise) begin
                    state_d = ssm_pkg::SSM_IDLE;
                end else if (sclk_rise) begin
                    state_d = ssm_pkg::SSM_SHIFTING;
                end
            end
            ssm_pkg::SSM_SHIFTING: begin
                if (cs_rise) begin
                    state_d = ssm_pkg::SSM_IDLE;
                end
            end
            default: begin
                state_d = ssm_pkg::SSM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= ssm_pkg::SSM_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************
    // status, shift and mask registers
    // ****************************************
    logic [WIDTH-1:0] status_q;
    logic [WIDTH-1:0] status_d;
    logic [WIDTH-1:0] shreg_q;
    logic [WIDTH-1:0] shreg_d;
    logic [WIDTH-1:0] mask_q;
    logic [WIDTH-1:0] mask_d;
    logic sdo_q;
    logic sdo_d;

    wire first_rise = sclk_rise & (state_q == ssm_pkg::SSM_SEL_WAIT);
    wire later_rise = sclk_rise & (state_q == ssm_pkg::SSM_SHIFTING);
    wire sw_reset = cs_rise & (shreg_q == ssm_pkg::SW_RESET_MASK[WIDTH-1:0]);

    // select fall captures held levels; zero mask at rise clears
    assign status_d = cs_fall ? held_d :
                      sw_reset ? ssm_pkg::STATUS_RESET[WIDTH-1:0] :
                      status_q;

    // rise presents msb; fall shifts left taking data in at bit 0
    assign shreg_d = first_rise ? status_q :
                     sclk_fall ? {shreg_q[WIDTH-2:0], sdi_s} :
                     shreg_q;

    assign mask_d = cs_rise ? shreg_q : mask_q;

    assign sdo_d = first_rise ? status_q[WIDTH-1] :
                   later_rise ? shreg_q[WIDTH-1] :
                   sdo_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            status_q <= ssm_pkg::STATUS_RESET[WIDTH-1:0];
            shreg_q <= '0;
            mask_q <= ssm_pkg::MASK_RESET[WIDTH-1:0];
            sdo_q <= 1'b0;
        end else begin
            status_q <= status_d;
            shreg_q <= shreg_d;
            mask_q <= mask_d;
            sdo_q <= sdo_d;
        end
    end

    // ****************************************
    // interrupt and serial output
    // ****************************************
    logic [WIDTH-1:0] diff_bits;
    logic irq_q;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_cmp
            // per-bit compare gated by mask
            assign diff_bits[gi] = (held_q[gi] ^ status_q[gi]) & mask_q[gi];
        end
    endgenerate

    // level, so it releases as soon as inputs match again
    wire irq_d = en_s & (|diff_bits);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // open drain: drive low only when asserted, wired-and outside
    assign irq_n_out = 1'b0;
    assign irq_n_oe = irq_q;
    assign shift_data_out = sdo_q;
    assign shift_data_out_oe = ~cs_n_s;
    assign status_out = status_q;
    assign mask_out = mask_q;

    // ****************************************
    // assertions
    // ****************************************
    sequence s_cs_fall;
        $fell(cs_n_s);
    endsequence

    a_irq_needs_enable: assert property (@(posedge clk_sys) disable iff (sys_rst)
        irq_n_oe |-> $past(en_s)) else $error("interrupt driven while disabled");

    a_irq_masked_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ($past(mask_q) == '0) |-> !irq_n_oe) else $error("interrupt with all masked");

    a_status_capture: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_cs_fall |=> (status_q == $past(held_d))) else $error("status not captured at select fall");

    a_irq_cleared: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_cs_fall ##1 (held_q == status_q) |=> !irq_n_oe) else $error("interrupt not cleared");

    a_mask_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(cs_n_s) |=> (mask_q == $past(shreg_q))) else $error("mask not stored at select rise");

    a_sw_reset: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ($rose(cs_n_s) && shreg_q == '0 && !cs_fall) |=> (status_q == '0)) else $error("software reset missed");

    a_msb_first: assert property (@(posedge clk_sys) disable iff (sys_rst)
        first_rise |=> (shift_data_out == status_q[WIDTH-1])) else $error("msb not presented");

    a_sdo_float: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cs_n_s |-> !shift_data_out_oe) else $error("serial output driven while deselected");

    a_sample_fall: assert property (@(posedge clk_sys) disable iff (sys_rst)
        sclk_fall |=> (shreg_q[0] == $past(sdi_s))) else $error("data input not sampled");

    a_mask_stable: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !$past(cs_rise) |-> $stable(mask_q)) else $error("mask changed outside select rise");

    // ****************************************
    // further checks on interrupt and shifting
    // ****************************************
    sequence s_cs_rise;
        $rose(cs_n_s);
    endsequence

    sequence s_first_rise;
        first_rise;
    endsequence

    // unmasked difference while enabled must pull the line
    a_irq_from_diff: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (en_s && (|diff_bits)) |=> irq_n_oe) else $error("interrupt missing on difference");

    // level compare, no latching of an old change
    a_irq_release: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (held_q == status_q) |=> !irq_n_oe) else $error("interrupt kept after match");

    a_irq_off_disabled: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !en_s |=> !irq_n_oe) else $error("interrupt driven with enable low");

    // held value frozen while inputs are switched off
    a_held_frozen: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !en_s |=> (held_q == $past(held_q))) else $error("held inputs moved while disabled");

    a_load_shreg: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_first_rise |=> (shreg_q == $past(status_q))) else $error("shift register not loaded");

    a_shift_next: assert property (@(posedge clk_sys) disable iff (sys_rst)
        later_rise |=> (shift_data_out == $past(shreg_q[WIDTH-1]))) else $error("next bit not presented");

    a_shift_in: assert property (@(posedge clk_sys) disable iff (sys_rst)
        sclk_fall |=> (shreg_q[WIDTH-1:1] == $past(shreg_q[WIDTH-2:0]))) else $error("shift register not shifted");

    // nothing moves the shift register while deselected
    a_ignore_desel: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (cs_n_s && cs_n_q) |=> $stable(shreg_q)) else $error("shift register moved while deselected");

    a_sdo_driven: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !cs_n_s |-> shift_data_out_oe) else $error("serial output not driven while selected");

    // zero shift register at select rise leaves a zero mask
    a_sw_reset_mask: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (s_cs_rise ##0 (shreg_q == '0)) |=> (mask_q == '0)) else $error("zero mask not stored");

    a_state_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_cs_rise |=> (state_q == ssm_pkg::SSM_IDLE)) else $error("state not idle after select rise");

    a_state_legal: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_q != 2'b10)) else $error("illegal serial state");

    // registers come out of reset cleared
    a_reset_clear: assert property (@(posedge clk_sys)
        $past(sys_rst) |-> (status_q == '0 && mask_q == '0 && !irq_n_oe)) else $error("reset did not clear");
endmodule

/* File: tb/ssm_host.sv */
// spi host model for the switch monitor's serial port
`timescale 1ns/1ps
module ssm_host (
    input wire logic clk_sys,
    output logic chip_select_n,
    output logic serial_clk,
    output logic shift_data_in,
    input wire logic shift_data_out,
    input wire logic shift_data_out_oe
);
    initial begin
        chip_select_n = 1'b1;
        serial_clk = 1'b0;
        shift_data_in = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    // mask goes in msb first while status comes out
    task automatic xfer(input logic [15:0] mask, output logic [15:0] rd, output logic oe_seen);
        wait_clk(1);
        chip_select_n = 1'b0;
        wait_clk(6);
        oe_seen = shift_data_out_oe;
        for (int i = 15; i >= 0; i--) begin
            shift_data_in = mask[i];
            serial_clk = 1'b1;
            wait_clk(4);
            rd[i] = shift_data_out;
            serial_clk = 1'b0;
            wait_clk(4);
        end
        chip_select_n = 1'b1;
        shift_data_in = ~shift_data_in;
        wait_clk(8);
    endtask
    // clock and data wiggled with no selection
    task automatic stray();
        for (int i = 0; i < 8; i++) begin
            shift_data_in = ~shift_data_in;
            serial_clk = 1'b1;
            wait_clk(4);
            serial_clk = 1'b0;
            wait_clk(4);
        end
    endtask
endmodule

/* File: tb/tb_spi_switch_input_monitor.sv */
// self-checking bench for the serial switch monitor
`timescale 1ns/1ps
module tb_spi_switch_input_monitor;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] pins = 16'h0000;
    logic input_enable = 1'b0;
    logic cs_n, sclk, sdi, sdo, sdo_oe, irq_n_out, irq_n_oe, oe_seen;
    logic [15:0] status_out, mask_out, rd, r, seen;
    logic [31:0] seed = 32'h0000_004F;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [15:0] exp_q[$];
    int sel_q[$];
    string names[5] = '{"status", "mask", "read", "irq_oe", "sdo_oe"};
    event obs_ev;
    always #12.5 clk_sys = ~clk_sys;
    ssm_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .switch_input_pins(pins), .input_enable(input_enable),
        .chip_select_n(cs_n), .serial_clk(sclk), .shift_data_in(sdi), .shift_data_out(sdo),
        .shift_data_out_oe(sdo_oe), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .status_out(status_out),
        .mask_out(mask_out));
    ssm_host host (.clk_sys(clk_sys), .chip_select_n(cs_n), .serial_clk(sclk), .shift_data_in(sdi),
        .shift_data_out(sdo), .shift_data_out_oe(sdo_oe));
    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic check(input string name, input logic [15:0] got, input logic [15:0] want);
        num_checks++;
        if (got !== want) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, want, got);
        end
    endtask
    task automatic note(input int sel, input logic [15:0] want);
        sel_q.push_back(sel);
        exp_q.push_back(want);
        ->obs_ev;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ************************************
    // monitor drains all queued notes, oldest first
    // ************************************
    always @(obs_ev) begin
        while (exp_q.size() > 0) begin
            case (sel_q[0])
                0: seen = status_out;
                1: seen = mask_out;
                2: seen = rd;
                3: seen = {15'h0000, irq_n_oe};
                default: seen = {15'h0000, oe_seen};
            endcase
            check(names[sel_q[0]], seen, exp_q[0]);
            void'(sel_q.pop_front());
            void'(exp_q.pop_front());
        end
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    // ************************************
    // scenarios
    // ************************************
    initial begin
        repeat (12) @(posedge clk_sys);
        #2 sys_rst = 1'b0;
        step(2);
        note(0, 16'h0000);
        note(1, 16'h0000);
        note(3, 16'h0000);
        $display("reset test done");
        input_enable = 1'b1;
        r = rnd();
        pins = r;
        step(4);
        host.xfer(16'hFFFF, rd, oe_seen);
        note(4, 16'h0001);
        note(2, r);
        note(0, r);
        note(1, 16'hFFFF);
        for (int k = 0; k < 16; k++) begin
            pins = r ^ (16'h0001 << k);
            step(8);
            note(3, 16'h0001);
            pins = r;
            step(8);
            note(3, 16'h0000);
        end
        $display("capture and change test done");
        host.xfer(16'h7FFF, rd, oe_seen);
        pins = r ^ 16'h8000;
        step(8);
        note(3, 16'h0000);
        pins = r ^ 16'h8001;
        step(8);
        note(3, 16'h0001);
        host.xfer(16'h7FFF, rd, oe_seen);
        note(2, r ^ 16'h8001);
        note(3, 16'h0000);
        $display("mask test done");
        input_enable = 1'b0;
        step(4);
        pins = ~(r ^ 16'h8001);
        step(8);
        note(3, 16'h0000);
        host.xfer(16'hFFFF, rd, oe_seen);
        note(2, r ^ 16'h8001);
        note(3, 16'h0000);
        host.stray();
        oe_seen = sdo_oe;
        note(1, 16'hFFFF);
        note(4, 16'h0000);
        $display("disable test done");
        input_enable = 1'b1;
        step(8);
        note(3, 16'h0001);
        host.xfer(16'h0000, rd, oe_seen);
        note(2, ~(r ^ 16'h8001));
        note(0, 16'h0000);
        note(1, 16'h0000);
        note(3, 16'h0000);
        $display("software reset test done");
        step(2);
        conclude();
    end
endmodule
